// ===== jtp_pkg.sv
// Functional notes
// R1 - debugger pulses test reset low after power-up
// R2 - test reset selects system mode for cells
// R3 - test reset makes identification read current
// R4 - sample and advance only on enabled edges
// R5 - chain select loads 1000 on capture
// R6 - update connects shifted chain until reselected
// R7 - test reset selects scan chain zero
// R8 - chain select register is four bits
// R9 - internal test connects selected chain serially
// R10 - internal test switches cells to test mode
// R11 - internal test capture grabs core and system
// R12 - internal test shift moves captured data out
// R13 - identification read connects 32-bit device_identification
// R14 - identification read keeps cells in system mode
// R15 - capture loads fixed id with layout
// R16 - device_identification unchanged on update
// R17 - bypass connects one bit, system untouched
// R18 - bypass captures zero, update leaves it
// R19 - bypass output lags input one enabled cycle
// R20 - unassigned instruction codes act as bypass
// R21 - restart behaves exactly as bypass
// R22 - restart signals debug exit entering idle
// R23 - 4-bit ir captures 0001, updates instruction
// R24 - reserved chain numbers shift out zeros
// R25 - sixteen-state controller steps on mode select
// R26 - serial registers leave least significant first
package jtp_pkg;

	// ==========================================================
	// instruction codes
	localparam logic [3:0] INSN_SCAN_SEL = 4'h2;
	localparam logic [3:0] INSN_INTEST   = 4'hc;
	localparam logic [3:0] INSN_IDREAD   = 4'he;
	localparam logic [3:0] INSN_BYPASS   = 4'hf;
	localparam logic [3:0] INSN_RESTART  = 4'h4;

	// ==========================================================
	// capture and reset values, path lengths
	localparam logic [3:0] IR_CAPTURE    = 4'h1;   // fixed pattern loaded in capture-ir
	localparam logic [3:0] SEL_CAPTURE   = 4'h8;   // fixed pattern loaded in capture-dr
	localparam logic [3:0] CHAIN_RESET   = 4'h0;   // chain selected after test reset
	localparam int         LEN_SEL       = 4;      // chain select register length
	localparam int         LEN_ID        = 32;     // identification register length
	localparam int         LEN_BYP       = 1;      // passthrough register length

	// ==========================================================
	// controller states
	typedef enum logic [3:0] {
		ST_RESET  = 4'b0000,
		ST_IDLE   = 4'b0001,
		ST_SEL_DR = 4'b0010,
		ST_CAP_DR = 4'b0011,
		ST_SH_DR  = 4'b0100,
		ST_EX1_DR = 4'b0101,
		ST_PA_DR  = 4'b0110,
		ST_EX2_DR = 4'b0111,
		ST_UPD_DR = 4'b1000,
		ST_SEL_IR = 4'b1001,
		ST_CAP_IR = 4'b1010,
		ST_SH_IR  = 4'b1011,
		ST_EX1_IR = 4'b1100,
		ST_PA_IR  = 4'b1101,
		ST_EX2_IR = 4'b1110,
		ST_UPD_IR = 4'b1111
	} jtp_state_t;

	// data path chosen by the current instruction
	typedef enum logic [1:0] {
		PATH_SEL   = 2'b00,
		PATH_CHAIN = 2'b01,
		PATH_ID    = 2'b10,
		PATH_BYP   = 2'b11
	} jtp_path_t;

	// ==========================================================
	// instruction decode, shared by logic and checks
	function automatic jtp_path_t jtp_decode(input logic [3:0] insn);
		jtp_path_t p;
		case (insn)
			INSN_SCAN_SEL: p = PATH_SEL;
			INSN_INTEST:   p = PATH_CHAIN;
			INSN_IDREAD:   p = PATH_ID;
			default:       p = PATH_BYP;   // bypass, restart and all unused codes [R20] [R21]
		endcase
		return p;
	endfunction

endpackage

// ===== jtp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module jtp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clocking
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             ce,
	// filling side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// draining side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	// ==========================================================
	// storage and pointers
	logic [WIDTH-1:0] mem_reg [DEPTH];     // word storage
	logic [AW-1:0]    wr_reg, wr_next;     // write index
	logic [AW-1:0]    rd_reg, rd_next;     // read index
	logic [AW:0]      cnt_reg, cnt_next;   // words held
	logic             rdy_reg, rdy_next;   // room flag, kept as a flop
	logic             val_reg, val_next;   // data flag, kept as a flop
	logic             push, pop;

	assign in_ready  = rdy_reg;
	assign out_valid = val_reg;
	assign out_data  = mem_reg[rd_reg];
	assign push      = ce & in_valid & rdy_reg;
	assign pop       = ce & out_ready & val_reg;

	// next pointers and flags
	always_comb begin
		wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
		rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
		cnt_next = cnt_reg;
		if (push && !pop) begin
			cnt_next = (AW+1)'(cnt_reg + 1'b1);
		end else if (pop && !push) begin
			cnt_next = (AW+1)'(cnt_reg - 1'b1);
		end
		// full and empty follow the count, so both stay honest
		rdy_next = (cnt_next != (AW+1)'(DEPTH));
		val_next = (cnt_next != '0);
	end

	// register pointers and flags
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
			rdy_reg <= 1'b1;
			val_reg <= 1'b0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
			rdy_reg <= rdy_next;
			val_reg <= val_next;
		end
	end

	// storage writes, no reset needed for data
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end

endmodule
`default_nettype wire

// ===== jtp_tap.sv
`timescale 1ns/1ps
`default_nettype none
module jtp_tap #(
	parameter logic [3:0]  ID_VERSION = 4'h1,        // arbitrary value
	parameter logic [15:0] ID_PART    = 16'h0001,    // arbitrary value
	parameter logic [10:0] ID_MAKER   = 11'h001,     // arbitrary value
	parameter int          WORD_W     = 8,
	parameter int          FIFO_DEPTH = 16
) (
	// clocking and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              ce,
	// debugger pins
	input  wire logic              serial_test_in,
	input  wire logic              test_mode_select_in,
	input  wire logic              test_clock_enable,
	input  wire logic              test_port_reset_n,
	output logic                   serial_test_out,
	// scan chain control
	output logic [3:0]             chain_select,
	output logic                   scan_test_mode,
	output logic                   chain_capture,
	output logic                   chain_shift,
	output logic                   chain_update,
	output logic                   chain_serial_in,
	input  wire logic              chain_serial_out,
	// processor control
	output logic                   debug_exit,
	// stream of words shifted into the chain
	output logic [WORD_W-1:0]      word_data,
	output logic                   word_valid,
	input  wire logic              word_ready,
	output logic                   word_room
);
	localparam int CW = $clog2(WORD_W);
	localparam logic [31:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

	// ==========================================================
	// pin synchronisers with agreement filter
	logic [2:0] s1_reg, s1_next;           // first stage, read only by s2
	logic [2:0] s2_reg, s2_next;
	logic [2:0] s3_reg, s3_next;
	logic [2:0] filt_reg, filt_next;       // {clock enable, data in, mode select}
	logic       ten_reg, ten_next;         // filtered enable has just risen
	logic       tms_f, tdi_f, en;

	assign tms_f = filt_reg[0];
	assign tdi_f = filt_reg[1];
	// one step per enable pulse: the filter passes no pulse shorter than
	// two cycles, so a plain level would always take at least two steps [R4]
	assign en    = ce & ten_reg;

	// next sync values, frozen while ce is low
	always_comb begin
		s1_next   = s1_reg;
		s2_next   = s2_reg;
		s3_next   = s3_reg;
		filt_next = filt_reg;
		ten_next  = ten_reg;
		if (ce) begin
			s1_next = {test_clock_enable, serial_test_in, test_mode_select_in};
			s2_next = s1_reg;
			s3_next = s2_reg;
			// a bit only moves once two stages agree, which rejects glitches
			for (int i = 0; i < 3; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					filt_next[i] = s3_reg[i];
				end
			end
			ten_next = filt_next[2] & ~filt_reg[2];
		end
	end

	// register sync stages
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_reg   <= 3'h0;
			s2_reg   <= 3'h0;
			s3_reg   <= 3'h0;
			filt_reg <= 3'h0;
			ten_reg  <= 1'b0;
		end else begin
			s1_reg   <= s1_next;
			s2_reg   <= s2_next;
			s3_reg   <= s3_next;
			filt_reg <= filt_next;
			ten_reg  <= ten_next;
		end
	end

	// ==========================================================
	// controller step
	function automatic jtp_pkg::jtp_state_t tap_step(input jtp_pkg::jtp_state_t s,
		input logic m);
		jtp_pkg::jtp_state_t n;
		case (s)
			jtp_pkg::ST_RESET:  n = m ? jtp_pkg::ST_RESET  : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_IDLE:   n = m ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_SEL_DR: n = m ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
			jtp_pkg::ST_CAP_DR: n = m ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
			jtp_pkg::ST_SH_DR:  n = m ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
			jtp_pkg::ST_EX1_DR: n = m ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PA_DR;
			jtp_pkg::ST_PA_DR:  n = m ? jtp_pkg::ST_EX2_DR : jtp_pkg::ST_PA_DR;
			jtp_pkg::ST_EX2_DR: n = m ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SH_DR;
			jtp_pkg::ST_UPD_DR: n = m ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_SEL_IR: n = m ? jtp_pkg::ST_RESET  : jtp_pkg::ST_CAP_IR;
			jtp_pkg::ST_CAP_IR: n = m ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
			jtp_pkg::ST_SH_IR:  n = m ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
			jtp_pkg::ST_EX1_IR: n = m ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PA_IR;
			jtp_pkg::ST_PA_IR:  n = m ? jtp_pkg::ST_EX2_IR : jtp_pkg::ST_PA_IR;
			jtp_pkg::ST_EX2_IR: n = m ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SH_IR;
			jtp_pkg::ST_UPD_IR: n = m ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			default:            n = jtp_pkg::ST_RESET;
		endcase
		return n;
	endfunction

	// shift one bit in at the top of a path, lsb leaves first
	function automatic logic [31:0] path_shift(input logic [31:0] d, input logic b,
		input int len);
		logic [31:0] r;
		r = d >> 1;
		r[len-1] = b;
		return r;
	endfunction

	// chain numbers with real chains behind them; others read as zeros
	function automatic logic chain_present(input logic [3:0] n);
		return (n == 4'h0) || (n == 4'h1) || (n == 4'h2) || (n == 4'hf);
	endfunction

	// ==========================================================
	// controller, instruction and data paths
	// test reset acts at once, like nrst, so both clear the port
	logic tap_rst_n;
	assign tap_rst_n = nrst & test_port_reset_n;

	jtp_pkg::jtp_state_t state_reg, state_next;
	jtp_pkg::jtp_path_t  path;
	logic [3:0]          irs_reg, irs_next;      // instruction shifter
	logic [3:0]          ir_reg, ir_next;        // current instruction
	logic [31:0]         dr_reg, dr_next;        // shared data shifter
	logic                tdo_reg, tdo_next;
	logic [3:0]          sel_reg, sel_next;      // active chain number
	logic                tm_reg, tm_next;        // scan cells in test mode
	logic                cap_reg, cap_next;
	logic                sh_reg, sh_next;
	logic                upd_reg, upd_next;
	logic                csi_reg, csi_next;
	logic                dx_reg, dx_next;
	logic [WORD_W-1:0]   pack_reg, pack_next;    // bits shifted into the chain
	logic [CW-1:0]       pcnt_reg, pcnt_next;
	logic                push_reg, push_next;
	logic [WORD_W-1:0]   pword_reg, pword_next;
	logic                fifo_room;

	assign path = jtp_pkg::jtp_decode(ir_reg);

	// next state of the whole port
	always_comb begin
		state_next = state_reg;
		irs_next   = irs_reg;
		ir_next    = ir_reg;
		dr_next    = dr_reg;
		tdo_next   = tdo_reg;
		sel_next   = sel_reg;
		tm_next    = tm_reg;
		cap_next   = 1'b0;
		sh_next    = 1'b0;
		upd_next   = 1'b0;
		csi_next   = csi_reg;
		dx_next    = 1'b0;
		pack_next  = pack_reg;
		pcnt_next  = pcnt_reg;
		push_next  = 1'b0;
		pword_next = pword_reg;
		if (!ce) begin
			// frozen: strobes hold as well
			cap_next  = cap_reg;
			sh_next   = sh_reg;
			upd_next  = upd_reg;
			dx_next   = dx_reg;
			push_next = push_reg;
		end else begin
			// cells follow the current instruction one clock later, on every ce cycle, without waiting for enable [R10] [R14] [R17]
			tm_next = (ir_reg == jtp_pkg::INSN_INTEST);
			if (en) begin
				state_next = tap_step(state_reg, tms_f);   // [R25]
				// restart: exit debug when idle is entered [R22]
				dx_next = (ir_reg == jtp_pkg::INSN_RESTART)
					&& (state_next == jtp_pkg::ST_IDLE) && (state_reg != jtp_pkg::ST_IDLE);
				case (state_reg)
					jtp_pkg::ST_RESET: begin
						ir_next = jtp_pkg::INSN_IDREAD;    // [R3]
					end
					jtp_pkg::ST_CAP_IR: begin
						irs_next = jtp_pkg::IR_CAPTURE;    // [R23]
					end
					jtp_pkg::ST_SH_IR: begin
						tdo_next = irs_reg[0];             // [R26]
						irs_next = {tdi_f, irs_reg[3:1]};  // [R23]
					end
					jtp_pkg::ST_UPD_IR: begin
						ir_next = irs_reg;                 // [R23]
					end
					jtp_pkg::ST_CAP_DR: begin
						case (path)
							jtp_pkg::PATH_SEL:   dr_next = {28'h000_0000, jtp_pkg::SEL_CAPTURE}; // [R5]
							jtp_pkg::PATH_ID:    dr_next = ID_VALUE;   // [R13] [R15]
							jtp_pkg::PATH_CHAIN: cap_next = 1'b1;      // [R11]
							default:             dr_next = 32'h0000_0000;   // [R18]
						endcase
						pcnt_next = '0;
					end
					jtp_pkg::ST_SH_DR: begin
						case (path)
							jtp_pkg::PATH_SEL: begin
								tdo_next = dr_reg[0];
								dr_next  = path_shift(dr_reg, tdi_f, jtp_pkg::LEN_SEL);  // [R8]
							end
							jtp_pkg::PATH_ID: begin
								tdo_next = dr_reg[0];
								dr_next  = path_shift(dr_reg, tdi_f, jtp_pkg::LEN_ID);   // [R13]
							end
							jtp_pkg::PATH_CHAIN: begin
								// selected chain sits between the pins [R9] [R12]
								tdo_next = chain_present(sel_reg) & chain_serial_out;    // [R24]
								sh_next  = 1'b1;
								csi_next = tdi_f;
								pack_next = {tdi_f, pack_reg[WORD_W-1:1]};
								pcnt_next = CW'(pcnt_reg + 1'b1);
								if (pcnt_reg == CW'(WORD_W - 1)) begin
									push_next  = 1'b1;
									pword_next = {tdi_f, pack_reg[WORD_W-1:1]};
								end
							end
							default: begin
								// one-bit delay from in to out [R17] [R19]
								tdo_next = dr_reg[0];
								dr_next  = path_shift(dr_reg, tdi_f, jtp_pkg::LEN_BYP);
							end
						endcase
					end
					jtp_pkg::ST_UPD_DR: begin
						// id and passthrough ignore update [R16] [R18]
						if (path == jtp_pkg::PATH_SEL) begin
							sel_next = dr_reg[3:0];            // [R6]
						end else if (path == jtp_pkg::PATH_CHAIN) begin
							upd_next = 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// register the port; test reset gives system mode, id read, chain 0
	always_ff @(posedge clk or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			state_reg <= jtp_pkg::ST_RESET;
			irs_reg   <= jtp_pkg::IR_CAPTURE;
			ir_reg    <= jtp_pkg::INSN_IDREAD;      // [R3]
			dr_reg    <= 32'h0000_0000;
			tdo_reg   <= 1'b0;
			sel_reg   <= jtp_pkg::CHAIN_RESET;      // [R7]
			tm_reg    <= 1'b0;                      // [R2]
			cap_reg   <= 1'b0;
			sh_reg    <= 1'b0;
			upd_reg   <= 1'b0;
			csi_reg   <= 1'b0;
			dx_reg    <= 1'b0;
			pack_reg  <= '0;
			pcnt_reg  <= '0;
			push_reg  <= 1'b0;
			pword_reg <= '0;
		end else begin
			state_reg <= state_next;
			irs_reg   <= irs_next;
			ir_reg    <= ir_next;
			dr_reg    <= dr_next;
			tdo_reg   <= tdo_next;
			sel_reg   <= sel_next;
			tm_reg    <= tm_next;
			cap_reg   <= cap_next;
			sh_reg    <= sh_next;
			upd_reg   <= upd_next;
			csi_reg   <= csi_next;
			dx_reg    <= dx_next;
			pack_reg  <= pack_next;
			pcnt_reg  <= pcnt_next;
			push_reg  <= push_next;
			pword_reg <= pword_next;
		end
	end

	assign serial_test_out = tdo_reg;
	assign chain_select    = sel_reg;
	assign scan_test_mode  = tm_reg;
	assign chain_capture   = cap_reg;
	assign chain_shift     = sh_reg;
	assign chain_update    = upd_reg;
	assign chain_serial_in = csi_reg;
	assign debug_exit      = dx_reg;
	assign word_room       = fifo_room;

	// ==========================================================
	// word buffer; a word pushed while full is dropped, room shows it
	jtp_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.ce        (ce),
		.in_valid  (push_reg),
		.in_data   (pword_reg),
		.in_ready  (fifo_room),
		.out_valid (word_valid),
		.out_data  (word_data),
		.out_ready (word_ready)
	);

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!tap_rst_n);

	property p_reset_id;
		(en && state_reg == jtp_pkg::ST_RESET) |=> (ir_reg == jtp_pkg::INSN_IDREAD);
	endproperty
	a_reset_id: assert property (p_reset_id) else $error("idle reset lost id read"); // [R3]

	property p_freeze;
		!en |=> $stable(state_reg);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved without enable"); // [R4]

	property p_sel_capture;
		(en && state_reg == jtp_pkg::ST_CAP_DR && path == jtp_pkg::PATH_SEL)
			|=> (dr_reg[3:0] == 4'h8);
	endproperty
	a_sel_capture: assert property (p_sel_capture) else $error("select capture wrong"); // [R5]

	property p_sel_hold;
		!(en && state_reg == jtp_pkg::ST_UPD_DR && path == jtp_pkg::PATH_SEL)
			|=> $stable(sel_reg);
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("chain changed unasked"); // [R6]

	property p_mode;
		(ce && ir_reg == jtp_pkg::INSN_INTEST) ##1 (ce && ir_reg == jtp_pkg::INSN_INTEST)
			|=> tm_reg;
	endproperty
	a_mode: assert property (p_mode) else $error("cells not in test mode"); // [R10]

	property p_sys_mode;
		(ir_reg != jtp_pkg::INSN_INTEST && ce) |=> !tm_reg;
	endproperty
	a_sys_mode: assert property (p_sys_mode) else $error("cells left system mode"); // [R14]

	property p_id_capture;
		(en && state_reg == jtp_pkg::ST_CAP_DR && path == jtp_pkg::PATH_ID)
			|=> (dr_reg == ID_VALUE && dr_reg[0]);
	endproperty
	a_id_capture: assert property (p_id_capture) else $error("id capture wrong"); // [R15]

	property p_byp_delay;
		(en && state_reg == jtp_pkg::ST_SH_DR && path == jtp_pkg::PATH_BYP)
			|=> (dr_reg[0] == $past(tdi_f) && tdo_reg == $past(dr_reg[0]));
	endproperty
	a_byp_delay: assert property (p_byp_delay) else $error("bypass delay wrong"); // [R19]

	property p_ir_capture;
		(en && state_reg == jtp_pkg::ST_CAP_IR) |=> (irs_reg == 4'h1);
	endproperty
	a_ir_capture: assert property (p_ir_capture) else $error("ir capture wrong"); // [R23]

	property p_reserved;
		(en && state_reg == jtp_pkg::ST_SH_DR && path == jtp_pkg::PATH_CHAIN
			&& !chain_present(sel_reg)) |=> !tdo_reg;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved chain not zero"); // [R24]

	property p_restart;
		(en && ir_reg == jtp_pkg::INSN_RESTART && state_reg == jtp_pkg::ST_UPD_DR && !tms_f)
			|=> (dx_reg && state_reg == jtp_pkg::ST_IDLE);
	endproperty
	a_restart: assert property (p_restart) else $error("no debug exit on idle"); // [R22]

	// enabled steps with mode select high in a row, saturating at five
	logic [2:0] ones_reg, ones_next;

	always_comb begin
		ones_next = ones_reg;
		if (en) begin
			ones_next = (!tms_f) ? 3'h0 : (ones_reg == 3'h5) ? 3'h5 : 3'(ones_reg + 3'h1);
		end
	end

	always_ff @(posedge clk or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			ones_reg <= 3'h0;
		end else begin
			ones_reg <= ones_next;
		end
	end

	property p_tms_reset;
		(ones_reg == 3'h5) |-> (state_reg == jtp_pkg::ST_RESET);
	endproperty
	a_tms_reset: assert property (p_tms_reset) else $error("five ones did not reset"); // [R25]

	c_sel_update: cover property (en && state_reg == jtp_pkg::ST_UPD_DR
		&& path == jtp_pkg::PATH_SEL);
	c_id_shift: cover property (en && state_reg == jtp_pkg::ST_SH_DR && path == jtp_pkg::PATH_ID);
	c_exit: cover property (dx_reg);
	c_word: cover property (push_reg && fifo_room);

endmodule
`default_nettype wire

// ===== jtp_dbg.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// debugger probe model: one controller step per call
module jtp_dbg (
	// clock
	input  wire logic clk,
	// probe pins
	output logic      serial_test_in,
	output logic      test_mode_select_in,
	output logic      test_clock_enable,
	output logic      test_port_reset_n,
	input  wire logic serial_test_out
);
	// pins idle with enable closed and test reset held low
	initial begin
		serial_test_in = 1'b0;
		test_mode_select_in = 1'b1;
		test_clock_enable = 1'b0;
		test_port_reset_n = 1'b0;
	end

	// pins settle through the filter before the enable opens
	task automatic step(input logic m, input logic d, output logic o);
		@(posedge clk);
		test_mode_select_in <= m;
		serial_test_in <= d;
		repeat (4) @(posedge clk);
		test_clock_enable <= 1'b1;
		repeat (2) @(posedge clk);
		test_clock_enable <= 1'b0;
		repeat (6) @(posedge clk);
		o = serial_test_out;
	endtask

	// low then high again, then walk into idle
	task automatic treset();
		logic o;
		@(posedge clk);
		test_port_reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		test_port_reset_n <= 1'b1;
		repeat (6) @(posedge clk);
		step(1'b0, 1'b0, o);
	endtask
endmodule
`default_nettype wire

// ===== jtag_tap_instruction_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
module jtag_tap_instruction_logic_test;
	// ==========================================================
	// signals
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        ce = 1'b1;
	logic        serial_test_in, test_mode_select_in, test_clock_enable;
	logic        test_port_reset_n, serial_test_out;
	logic [3:0]  chain_select;
	logic        scan_test_mode, chain_capture, chain_shift, chain_update;
	logic        chain_serial_in, chain_serial_out, debug_exit;
	logic [7:0]  word_data;
	logic        word_valid, word_room;
	logic        word_ready = 1'b0;
	logic [7:0]  csr = 8'h00;     // chain contents seen by the port
	logic [7:0]  cap_val = 8'h00; // value the chain captures
	logic [7:0]  exp_q[$];        // words still expected on the stream
	logic [31:0] d, r;
	logic        step_o;          // serial out of a bare controller step
	int          fail_count = 0, n_checks = 0, exit_cnt = 0, cap_cnt = 0;
	// id fields are arbitrary values
	localparam logic [31:0] ID_EXP = {4'h3, 16'h0a5c, 11'h2b1, 1'b1};

	always #2.5 clk = ~clk;

	jtp_dbg u_dbg (.clk, .serial_test_in, .test_mode_select_in,
		.test_clock_enable, .test_port_reset_n, .serial_test_out);

	jtp_tap #(.ID_VERSION(4'h3), .ID_PART(16'h0a5c), .ID_MAKER(11'h2b1)) u_dut (
		.clk, .nrst, .ce, .serial_test_in, .test_mode_select_in,
		.test_clock_enable, .test_port_reset_n, .serial_test_out,
		.chain_select, .scan_test_mode, .chain_capture, .chain_shift,
		.chain_update, .chain_serial_in, .chain_serial_out, .debug_exit,
		.word_data, .word_valid, .word_ready, .word_room);

	// ==========================================================
	// scan chain stand-in, lsb nearest the serial output
	always @(posedge clk) begin
		if (chain_capture === 1'b1) begin
			csr <= cap_val;
			cap_cnt <= cap_cnt + 1;
		end else if (chain_shift === 1'b1)
			csr <= {chain_serial_in, csr[7:1]};
		if (debug_exit === 1'b1)
			exit_cnt <= exit_cnt + 1;
	end
	assign chain_serial_out = csr[0];

	// ==========================================================
	// checking
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	// word stream scoreboard
	always @(posedge clk) begin
		if (word_valid === 1'b1 && word_ready === 1'b1) begin
			if (exp_q.size() == 0)
				chk(32'd1, 32'd0, "extra word");
			else
				chk(32'(word_data), 32'(exp_q.pop_front()), "word");
		end
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================================
	// scan from idle back to idle, lsb first
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
			output logic [31:0] dout);
		logic o;
		dout = '0;
		u_dbg.step(1'b1, 1'b0, o);
		if (ir)
			u_dbg.step(1'b1, 1'b0, o);
		u_dbg.step(1'b0, 1'b0, o);
		u_dbg.step(1'b0, 1'b0, o);
		for (int k = 0; k < n; k++) begin
			u_dbg.step(k == n - 1, din[k], o);
			dout[k] = o;
		end
		u_dbg.step(1'b1, 1'b0, o);
		u_dbg.step(1'b0, 1'b0, o);
	endtask

	task automatic ld(input logic [3:0] c);
		logic [31:0] q;
		scan(1'b1, 4, 32'(c), q);
		chk(q, 32'h0000_0001, "ir capture");
	endtask

	// fixed-order tests; each step is about 13 clocks
	initial begin
		void'($urandom(32'h7fc6));
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		for (int t = 0; t < 2; t++) begin
			u_dbg.treset();
			chk(chain_select, 0, "chain after reset");
			chk(scan_test_mode, 0, "mode after reset");
			scan(1'b0, 32, $urandom, d);
			chk(d, ID_EXP, "id");
			scan(1'b0, 32, $urandom, d);
			chk(d, ID_EXP, "id again");
			$display("test reset and id done");
			if (t == 1) begin
				ld(jtp_pkg::INSN_BYPASS);
				repeat (5) u_dbg.step(1'b1, 1'b0, step_o);
				u_dbg.step(1'b0, 1'b0, step_o);
				scan(1'b0, 32, $urandom, d);
				chk(d, ID_EXP, "id after five ones");
			end
			if (t == 0) begin
				ld(jtp_pkg::INSN_SCAN_SEL);
				scan(1'b0, 4, 32'h0000_0001, d);
				chk(d, 32'(jtp_pkg::SEL_CAPTURE), "select capture");
				chk(chain_select, 1, "chain");
				for (int c = 0; c < 5; c++) begin
					ld(c == 0 ? 4'hf : c == 1 ? 4'h4 : 4'(c * 3 + 1));
					r = $urandom;
					scan(1'b0, 8, r, d);
					chk(d, {24'h00_0000, r[6:0], 1'b0}, "bypass");
					chk(scan_test_mode, 0, "bypass mode");
				end
				chk(exit_cnt, 2, "restart exits");
				chk(chain_select, 1, "chain kept");
				$display("test bypass family done");
				ld(jtp_pkg::INSN_INTEST);
				chk(scan_test_mode, 1, "test mode");
				for (int w = 0; w < 17; w++) begin
					cap_val <= 8'($urandom);
					r = $urandom;
					scan(1'b0, 8, r, d);
					chk(d, 32'(cap_val), "chain out");
					if (w < 16)
						exp_q.push_back(r[7:0]);
				end
				chk(cap_cnt, 17, "captures");
				chk(word_room, 0, "fifo full");
				repeat (200) @(posedge clk) word_ready <= 1'($urandom);
				word_ready <= 1'b1;
				repeat (20) @(posedge clk);
				chk(exp_q.size(), 0, "words left");
				chk(word_valid, 0, "fifo empty");
				ld(jtp_pkg::INSN_SCAN_SEL);
				scan(1'b0, 4, 32'h0000_0003, d);
				ld(jtp_pkg::INSN_INTEST);
				r = $urandom;
				exp_q.push_back(r[7:0]);
				scan(1'b0, 8, r, d);
				chk(d, 0, "reserved chain");
				$display("test intest and stream done");
			end
		end
		test_done();
	end

	// watchdog, roughly three times the expected run
	initial begin
		#120us;
		fail_count++;
		test_done();
	end
endmodule
`default_nettype wire
